// ==== include/tccm_pkg.sv ====
// Purpose: constants and carriers for the timer channel mode control block
// Assumes: 16-bit register data, 8-bit byte address, 16-bit counter
// Notes:   the list below is the behaviour contract of the block
// Contract
// [R1] ch1 select 00 output, 01 input one, 10 input two, 11 internal trigger
// [R2] software changes a direction select only while that channel is disabled
// [R3] fast enable shortens trigger-to-output response of the compare output
// [R4] preload off: a compare value write takes effect at once
// [R5] preload on: written compare value waits for the next update event
// [R6] protection level 3 on an output channel locks preload and mode fields
// [R7] mode 000 freezes the reference level
// [R8] mode 001 drives reference high on counter match
// [R9] mode 010 drives reference low on counter match
// [R10] mode 011 toggles reference on each counter match
// [R11] mode 100 forces reference low, mode 101 forces it high
// [R12] mode 110 reference high while counter below compare, else low
// [R13] mode 111 reference high while counter above compare, else low
// [R14] pwm modes follow comparison changes and the switch from freeze
// [R15] clear enable lets a high filtered external trigger force reference low
// [R16] channel 2 mirrors channel 1 at bits 15:8
// [R17] software uses pwm with uncertain preload only in single pulse mode
// [R18] update generate restarts the counter and raises an update event
// [R19] mode register resets to all zeros
package tccm_pkg;

  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [7:0]  CEG_OFFSET    = 8'h14;
  localparam logic [7:0]  CCM_OFFSET    = 8'h18;
  localparam logic [7:0]  CMP1_OFFSET   = 8'h34;
  localparam logic [7:0]  CMP_STRIDE    = 8'h04;
  localparam logic [7:0]  STATUS_OFFSET = 8'h40;
  localparam logic [15:0] CCM_RESET     = 16'h0000;
  localparam int          UEG_BIT       = 0;
  localparam int          CH_WIDTH      = 8;
  localparam logic [1:0]  PROT_LOCK     = 2'h3;

  // ************************************************************
  // field encodings
  // ************************************************************
  localparam logic [1:0] SEL_OUTPUT = 2'h0;
  localparam logic [1:0] SEL_IN_ONE = 2'h1;
  localparam logic [1:0] SEL_IN_TWO = 2'h2;
  localparam logic [1:0] SEL_TRG    = 2'h3;
  localparam logic [2:0] MODE_FREEZE = 3'h0;
  localparam logic [2:0] MODE_SET    = 3'h1;
  localparam logic [2:0] MODE_CLEAR  = 3'h2;
  localparam logic [2:0] MODE_TOGGLE = 3'h3;
  localparam logic [2:0] MODE_LOW    = 3'h4;
  localparam logic [2:0] MODE_HIGH   = 3'h5;
  localparam logic [2:0] MODE_PWM1   = 3'h6;
  localparam logic [2:0] MODE_PWM2   = 3'h7;

  // ************************************************************
  // carriers
  // ************************************************************
  // one channel's byte of the mode register, msb first
  typedef struct packed {
    logic       clear_enable;
    logic [2:0] compare_mode;
    logic       preload_enable;
    logic       fast_enable;
    logic [1:0] direction_select;
  } tccm_ch_field_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } tccm_bus_req_t;

  typedef struct packed {
    logic timer_input_one;
    logic timer_input_two;
    logic internal_trigger_source;
    logic filtered_external_trigger;
    logic trigger_event;
  } tccm_trig_t;

endpackage : tccm_pkg

// ==== verilog/tccm_channel_ctrl.sv ====
// Purpose: mode register and reference level logic for timer channels 1 and 2
// Assumes: counter, triggers and pins are synchronous to ref_clk
// Notes:   compare values and the update generate bit live in the same register port
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/100ps

module tccm_channel_ctrl (
  input  wire logic                    ref_clk,
  input  wire logic                    resetn,
  input  wire tccm_pkg::tccm_bus_req_t bus_req,
  output logic [15:0]                  rdata,
  input  wire logic [15:0]             counter_value,
  input  wire logic                    update_event,
  input  wire logic [1:0]              channel_enable,
  input  wire logic [1:0]              protection_level,
  input  wire tccm_pkg::tccm_trig_t    trig,
  output logic [1:0]                   reference_level,
  output logic [1:0]                   capture_input,
  output logic                         counter_reinit
);

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic [15:0]      ccm;
    logic [1:0][15:0] preload;
    logic [1:0][15:0] active;
    logic [1:0]       ref_lvl;
    logic [1:0]       cap;
    logic [15:0]      rdata;
    logic             reinit;
  } tccm_state_t;

  tccm_state_t s_reg;
  tccm_state_t s_next;

  // ************************************************************
  // helpers
  // ************************************************************
  // channel fields out of the mode register
  function automatic tccm_pkg::tccm_ch_field_t ch_field(input logic [15:0] ccm, input int idx);
    ch_field = tccm_pkg::tccm_ch_field_t'(ccm[idx*tccm_pkg::CH_WIDTH +: tccm_pkg::CH_WIDTH]);
  endfunction : ch_field

  // compare register address of a channel
  function automatic logic [7:0] cmp_addr(input int idx);
    cmp_addr = tccm_pkg::CMP1_OFFSET + (idx[0] ? tccm_pkg::CMP_STRIDE : 8'h00);
  endfunction : cmp_addr

  // next reference level; force acts as a compare hit caused by the trigger
  function automatic logic ref_eval(input logic [2:0] mode, input logic cur, input logic [15:0] cnt,
                                    input logic [15:0] cmp, input logic force_hit);
    logic hit;
    hit = force_hit || (cnt == cmp);
    case (mode)
      tccm_pkg::MODE_FREEZE : ref_eval = cur;                        // R7
      tccm_pkg::MODE_SET    : ref_eval = hit ? 1'b1 : cur;           // R8
      tccm_pkg::MODE_CLEAR  : ref_eval = hit ? 1'b0 : cur;           // R9
      tccm_pkg::MODE_TOGGLE : ref_eval = hit ? ~cur : cur;           // R10
      tccm_pkg::MODE_LOW    : ref_eval = 1'b0;                       // R11
      tccm_pkg::MODE_HIGH   : ref_eval = 1'b1;                       // R11
      tccm_pkg::MODE_PWM1   : ref_eval = !force_hit && (cnt < cmp);  // R12
      tccm_pkg::MODE_PWM2   : ref_eval = force_hit || (cnt > cmp);   // R13
      default               : ref_eval = cur;
    endcase
  endfunction : ref_eval

  // ************************************************************
  // next state
  // ************************************************************
  tccm_pkg::tccm_ch_field_t cur_f;
  tccm_pkg::tccm_ch_field_t new_f;
  tccm_pkg::tccm_ch_field_t f0;
  tccm_pkg::tccm_ch_field_t f1;
  logic                     ueg_wr;
  logic                     upd;

  // one process for every register; channels share the loop body
  always_comb
  begin
    s_next        = s_reg;
    s_next.rdata  = 16'h0000;
    cur_f         = '0;
    new_f         = '0;
    ueg_wr        = bus_req.wr && (bus_req.addr == tccm_pkg::CEG_OFFSET) && bus_req.wdata[tccm_pkg::UEG_BIT];
    upd           = ueg_wr || update_event;
    s_next.reinit = ueg_wr;                                          // R18
    for (int i = 0; i < 2; i++)
    begin
      cur_f = ch_field(s_reg.ccm, i);                                // R16
      // mode register write with its lock conditions
      if (bus_req.wr && bus_req.addr == tccm_pkg::CCM_OFFSET)
      begin
        new_f = tccm_pkg::tccm_ch_field_t'(bus_req.wdata[i*tccm_pkg::CH_WIDTH +: tccm_pkg::CH_WIDTH]);
        if (channel_enable[i])
          new_f.direction_select = cur_f.direction_select;           // R2
        if (protection_level == tccm_pkg::PROT_LOCK && cur_f.direction_select == tccm_pkg::SEL_OUTPUT)
        begin
          new_f.preload_enable = cur_f.preload_enable;               // R6
          new_f.compare_mode   = cur_f.compare_mode;                 // R6
        end
        s_next.ccm[i*tccm_pkg::CH_WIDTH +: tccm_pkg::CH_WIDTH] = new_f;
      end
      // update event moves the buffered value first; a same-cycle write with preload on only reaches the buffer
      if (upd && cur_f.preload_enable)
        s_next.active[i] = s_reg.preload[i];                         // R5 R18
      if (bus_req.wr && bus_req.addr == cmp_addr(i))
      begin
        s_next.preload[i] = bus_req.wdata;
        if (!cur_f.preload_enable)
          s_next.active[i] = bus_req.wdata;                          // R4
      end
      // reference level runs every cycle while the channel selects output so pwm tracks any comparison change
      if (cur_f.direction_select == tccm_pkg::SEL_OUTPUT)
      begin
        s_next.ref_lvl[i] = ref_eval(cur_f.compare_mode, s_reg.ref_lvl[i], counter_value, s_reg.active[i],
                                     cur_f.fast_enable && trig.trigger_event);   // R3 R14
        if (cur_f.clear_enable && trig.filtered_external_trigger)
          s_next.ref_lvl[i] = 1'b0;                                  // R15
      end
      // capture source; channel 2 sees the two pins crossed
      case (cur_f.direction_select)
        tccm_pkg::SEL_IN_ONE : s_next.cap[i] = (i == 0) ? trig.timer_input_one : trig.timer_input_two;  // R1
        tccm_pkg::SEL_IN_TWO : s_next.cap[i] = (i == 0) ? trig.timer_input_two : trig.timer_input_one;  // R1
        tccm_pkg::SEL_TRG    : s_next.cap[i] = trig.internal_trigger_source;                            // R1
        default              : s_next.cap[i] = 1'b0;
      endcase
    end
    // read data valid only in the cycle after the strobe
    if (bus_req.rd)
    begin
      case (bus_req.addr)
        tccm_pkg::CCM_OFFSET    : s_next.rdata = s_reg.ccm;
        tccm_pkg::CMP1_OFFSET   : s_next.rdata = s_reg.preload[0];
        cmp_addr(1)             : s_next.rdata = s_reg.preload[1];
        tccm_pkg::STATUS_OFFSET : s_next.rdata = {10'h000, s_reg.cap, s_reg.ref_lvl,
                                   f1.direction_select == tccm_pkg::SEL_OUTPUT,
                                   f0.direction_select == tccm_pkg::SEL_OUTPUT};
        default                 : s_next.rdata = 16'h0000;
      endcase
    end
  end

  // ************************************************************
  // registers
  // ************************************************************
  // synchronous reset; everything clears to zero
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      s_reg     <= '0;
      s_reg.ccm <= tccm_pkg::CCM_RESET;                              // R19
    end
    else
      s_reg <= s_next;
  end

  assign rdata           = s_reg.rdata;
  assign reference_level = s_reg.ref_lvl;
  assign capture_input   = s_reg.cap;
  assign counter_reinit  = s_reg.reinit;

  // ************************************************************
  // checks
  // ************************************************************
  logic                     wr_ccm;
  logic                     wr_cmp0;
  logic                     hit0;
  logic                     quiet0;
  logic                     quiet1;

  // helper terms for channel 1, with f1 and quiet1 for channel 2
  always_comb
  begin
    f0      = ch_field(s_reg.ccm, 0);
    f1      = ch_field(s_reg.ccm, 1);
    wr_ccm  = bus_req.wr && bus_req.addr == tccm_pkg::CCM_OFFSET;
    wr_cmp0 = bus_req.wr && bus_req.addr == tccm_pkg::CMP1_OFFSET;
    hit0    = counter_value == s_reg.active[0];
    quiet0  = f0.direction_select == tccm_pkg::SEL_OUTPUT && !wr_ccm
              && !(f0.clear_enable && trig.filtered_external_trigger)
              && !(f0.fast_enable && trig.trigger_event);
    // same quiet condition for channel 2
    quiet1  = f1.direction_select == tccm_pkg::SEL_OUTPUT && !wr_ccm
              && !(f1.clear_enable && trig.filtered_external_trigger)
              && !(f1.fast_enable && trig.trigger_event);
  end

  property p_select_one;
    @(posedge ref_clk) disable iff (!resetn)
      f0.direction_select == tccm_pkg::SEL_IN_ONE && !wr_ccm |=> capture_input[0] == $past(trig.timer_input_one);
  endproperty
  a_select_one : assert property (p_select_one) else $error("ch1 capture not from input one"); // R1

  property p_select_lock;
    @(posedge ref_clk) disable iff (!resetn)
      wr_ccm && channel_enable[0] |=> f0.direction_select == $past(f0.direction_select);
  endproperty
  a_select_lock : assert property (p_select_lock) else $error("select changed while enabled"); // R2

  property p_fast;
    @(posedge ref_clk) disable iff (!resetn)
      f0.direction_select == tccm_pkg::SEL_OUTPUT && !wr_ccm && f0.fast_enable
      && trig.trigger_event && !(f0.clear_enable && trig.filtered_external_trigger)
      && f0.compare_mode == tccm_pkg::MODE_SET |=> reference_level[0];
  endproperty
  a_fast : assert property (p_fast) else $error("fast trigger did not act"); // R3

  property p_immediate;
    @(posedge ref_clk) disable iff (!resetn)
      wr_cmp0 && !f0.preload_enable |=> s_reg.active[0] == $past(bus_req.wdata);
  endproperty
  a_immediate : assert property (p_immediate) else $error("compare write not immediate"); // R4

  property p_buffered;
    @(posedge ref_clk) disable iff (!resetn)
      wr_cmp0 && f0.preload_enable && !update_event && !(bus_req.addr == tccm_pkg::CEG_OFFSET)
      ##1 !update_event && !(bus_req.wr && bus_req.addr == tccm_pkg::CEG_OFFSET) && !wr_cmp0
      |=> s_reg.active[0] == $past(s_reg.active[0], 2);
  endproperty
  a_buffered : assert property (p_buffered) else $error("preloaded value leaked early"); // R5

  property p_update;
    @(posedge ref_clk) disable iff (!resetn)
      update_event && f0.preload_enable && !wr_cmp0 |=> s_reg.active[0] == $past(s_reg.preload[0]);
  endproperty
  a_update : assert property (p_update) else $error("update did not load compare"); // R5

  property p_protect;
    @(posedge ref_clk) disable iff (!resetn)
      wr_ccm && protection_level == tccm_pkg::PROT_LOCK && f0.direction_select == tccm_pkg::SEL_OUTPUT
      |=> f0.compare_mode == $past(f0.compare_mode)
          && f0.preload_enable == $past(f0.preload_enable);
  endproperty
  a_protect : assert property (p_protect) else $error("locked field changed"); // R6

  property p_freeze;
    @(posedge ref_clk) disable iff (!resetn)
      quiet0 && f0.compare_mode == tccm_pkg::MODE_FREEZE |=> $stable(reference_level[0]);
  endproperty
  a_freeze : assert property (p_freeze) else $error("frozen level moved"); // R7

  property p_set;
    @(posedge ref_clk) disable iff (!resetn)
      quiet0 && f0.compare_mode == tccm_pkg::MODE_SET && hit0 |=> reference_level[0];
  endproperty
  a_set : assert property (p_set) else $error("match did not set"); // R8

  property p_clear;
    @(posedge ref_clk) disable iff (!resetn)
      quiet0 && f0.compare_mode == tccm_pkg::MODE_CLEAR && hit0 |=> !reference_level[0];
  endproperty
  a_clear : assert property (p_clear) else $error("match did not clear"); // R9

  property p_toggle;
    @(posedge ref_clk) disable iff (!resetn)
      quiet0 && f0.compare_mode == tccm_pkg::MODE_TOGGLE && hit0 |=> reference_level[0] != $past(reference_level[0]);
  endproperty
  a_toggle : assert property (p_toggle) else $error("match did not toggle"); // R10

  property p_forced;
    @(posedge ref_clk) disable iff (!resetn)
      quiet0 && f0.compare_mode[2:1] == 2'h2 |=> reference_level[0] == $past(f0.compare_mode[0]);
  endproperty
  a_forced : assert property (p_forced) else $error("forced level wrong"); // R11

  property p_pwm1;
    @(posedge ref_clk) disable iff (!resetn)
      quiet0 && f0.compare_mode == tccm_pkg::MODE_PWM1
      |=> reference_level[0] == ($past(counter_value) < $past(s_reg.active[0]));
  endproperty
  a_pwm1 : assert property (p_pwm1) else $error("pwm1 level wrong"); // R12 R14

  property p_pwm2;
    @(posedge ref_clk) disable iff (!resetn)
      quiet0 && f0.compare_mode == tccm_pkg::MODE_PWM2
      |=> reference_level[0] == ($past(counter_value) > $past(s_reg.active[0]));
  endproperty
  a_pwm2 : assert property (p_pwm2) else $error("pwm2 level wrong"); // R13 R14

  property p_ext_clear;
    @(posedge ref_clk) disable iff (!resetn)
      f0.direction_select == tccm_pkg::SEL_OUTPUT && f0.clear_enable && trig.filtered_external_trigger
      |=> !reference_level[0];
  endproperty
  a_ext_clear : assert property (p_ext_clear) else $error("external clear ignored"); // R15

  property p_reinit;
    @(posedge ref_clk) disable iff (!resetn)
      bus_req.wr && bus_req.addr == tccm_pkg::CEG_OFFSET && bus_req.wdata[tccm_pkg::UEG_BIT]
      |=> counter_reinit;
  endproperty
  a_reinit : assert property (p_reinit) else $error("update generate lost"); // R18

  // a reinit pulse with no software request would restart the counter at random
  property p_reinit_pulse;
    @(posedge ref_clk) disable iff (!resetn)
      counter_reinit |-> $past(ueg_wr);
  endproperty
  a_reinit_pulse : assert property (p_reinit_pulse) else $error("reinit without update generate"); // R18

  property p_select_two;
    @(posedge ref_clk) disable iff (!resetn)
      f1.direction_select == tccm_pkg::SEL_IN_ONE |=> capture_input[1] == $past(trig.timer_input_two);
  endproperty
  a_select_two : assert property (p_select_two) else $error("ch2 capture not from input two"); // R1 R16

  property p_out_no_cap;
    @(posedge ref_clk) disable iff (!resetn)
      f0.direction_select == tccm_pkg::SEL_OUTPUT |=> !capture_input[0];
  endproperty
  a_out_no_cap : assert property (p_out_no_cap) else $error("capture seen in output mode"); // R1

  property p_input_hold;
    @(posedge ref_clk) disable iff (!resetn)
      f0.direction_select != tccm_pkg::SEL_OUTPUT |=> $stable(reference_level[0]);
  endproperty
  a_input_hold : assert property (p_input_hold) else $error("reference moved in input mode"); // R1

  property p_high2;
    @(posedge ref_clk) disable iff (!resetn)
      quiet1 && f1.compare_mode == tccm_pkg::MODE_HIGH |=> reference_level[1];
  endproperty
  a_high2 : assert property (p_high2) else $error("ch2 forced high wrong"); // R11 R16

  property p_clear2;
    @(posedge ref_clk) disable iff (!resetn)
      quiet1 && f1.compare_mode == tccm_pkg::MODE_CLEAR && counter_value == s_reg.active[1] |=> !reference_level[1];
  endproperty
  a_clear2 : assert property (p_clear2) else $error("ch2 match did not clear"); // R9 R16

  property p_pwm2_ch2;
    @(posedge ref_clk) disable iff (!resetn)
      quiet1 && f1.compare_mode == tccm_pkg::MODE_PWM2
      |=> reference_level[1] == ($past(counter_value) > $past(s_reg.active[1]));
  endproperty
  a_pwm2_ch2 : assert property (p_pwm2_ch2) else $error("ch2 pwm2 level wrong"); // R13 R16

  property p_read_mode;
    @(posedge ref_clk) disable iff (!resetn)
      bus_req.rd && bus_req.addr == tccm_pkg::CCM_OFFSET |=> rdata == $past(s_reg.ccm);
  endproperty
  a_read_mode : assert property (p_read_mode) else $error("mode read wrong"); // R16

  property p_reset;
    @(posedge ref_clk)
      !resetn |=> s_reg.ccm == tccm_pkg::CCM_RESET && reference_level == 2'h0 && !counter_reinit;
  endproperty
  a_reset : assert property (p_reset) else $error("reset value wrong"); // R19

endmodule : tccm_channel_ctrl

// ==== verification/tccm_counter_model.sv ====
// Purpose: behavioural timer counter beside the channel mode block
// Assumes: bench steers the count through count_target, one cycle late
// Notes:   software reinit clears the count and raises one update pulse
`timescale 1ns/100ps

module tccm_counter_model (
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  input  wire logic [15:0] count_target,
  input  wire logic        counter_reinit,
  output logic [15:0]      counter_value,
  output logic             update_event
);
  // ****************************************
  // counter and update event
  // ****************************************
  // reinit wins over the steered count, as a real restart would
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      counter_value <= 16'h0000;
      update_event  <= 1'b0;
    end
    else
    begin
      counter_value <= counter_reinit ? 16'h0000 : count_target;
      update_event  <= counter_reinit;
    end
  end
endmodule : tccm_counter_model

// ==== verification/tccm_channel_ctrl_test.sv ====
// Purpose: self-checking bench for the channel mode block
// Assumes: register port with one-cycle read data, counter from the model
// Notes:   select changes are made with both channels disabled, except the select lock check with channel 1 enabled
`timescale 1ns/100ps

module tccm_channel_ctrl_test;
  logic                    ref_clk;
  logic                    resetn;
  tccm_pkg::tccm_bus_req_t bus_req;
  logic [15:0]             rdata;
  logic [15:0]             counter_value;
  logic [15:0]             count_target;
  logic                    update_event;
  logic                    counter_reinit;
  logic [1:0]              channel_enable;
  logic [1:0]              protection_level;
  tccm_pkg::tccm_trig_t    trig;
  logic [1:0]              reference_level;
  logic [1:0]              capture_input;
  int                      n_errors;
  int                      num_checks;
  int                      cycles;

  tccm_channel_ctrl tccm_channel_ctrl_i (.ref_clk(ref_clk), .resetn(resetn), .bus_req(bus_req), .rdata(rdata),
    .counter_value(counter_value), .update_event(update_event), .channel_enable(channel_enable),
    .protection_level(protection_level), .trig(trig), .reference_level(reference_level),
    .capture_input(capture_input), .counter_reinit(counter_reinit));
  tccm_counter_model tccm_counter_model_i (.ref_clk(ref_clk), .resetn(resetn), .count_target(count_target),
    .counter_reinit(counter_reinit), .counter_value(counter_value), .update_event(update_event));

  // ****************************************
  // clock and hang guard
  // ****************************************
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // whole run is well under a thousand cycles
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_errors++;
      print_verdict();
    end
  end

  // ****************************************
  // tasks
  // ****************************************
  task automatic print_verdict();
    if (n_errors == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : print_verdict

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] seen);
    num_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // gap cycle after each access keeps one assignment per time step
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    bus_req <= '0;
  endtask : wr

  task automatic rd_chk(input string name, input logic [7:0] a, input logic [15:0] exp);
    @(posedge ref_clk);
    bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    bus_req <= '0;
    #1 chk(name, exp, rdata);
  endtask : rd_chk

  task automatic ref_chk(input logic [1:0] exp);
    repeat (2) @(posedge ref_clk);
    #1 chk("reference_level", {14'h0000, exp}, {14'h0000, reference_level});
  endtask : ref_chk

  task automatic set_cnt(input logic [15:0] v);
    @(posedge ref_clk);
    count_target <= v;
    repeat (2) @(posedge ref_clk);
  endtask : set_cnt

  // counter sits on the compare value for exactly one cycle
  task automatic one_match();
    @(posedge ref_clk);
    count_target <= 16'h0010;
    @(posedge ref_clk);
    count_target <= 16'h0011;
  endtask : one_match

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    resetn = 1'b0;
    bus_req = '0;
    count_target = 16'h0000;
    channel_enable = 2'h0;
    protection_level = 2'h0;
    trig = '0;
    n_errors = 0;
    num_checks = 0;
    cycles = 0;
    repeat (2) @(posedge ref_clk);
    resetn <= 1'b1;
    rd_chk("mode", 8'h18, 16'h0000);
    @(posedge ref_clk);
    #1 chk("rdata_idle", 16'h0000, rdata);
    rd_chk("status", 8'h40, 16'h0003);
    wr(8'h34, 16'h0010);
    wr(8'h38, 16'h0010);
    rd_chk("compare_two", 8'h38, 16'h0010);
    wr(8'h18, 16'h5010);
    ref_chk(2'b10);
    set_cnt(16'h0010);
    ref_chk(2'b11);
    wr(8'h18, 16'h2010);
    ref_chk(2'b01);
    set_cnt(16'h0011);
    wr(8'h18, 16'h4030);
    ref_chk(2'b01);
    one_match();
    ref_chk(2'b00);
    one_match();
    ref_chk(2'b01);
    wr(8'h18, 16'h0000);
    one_match();
    ref_chk(2'b01);
    wr(8'h18, 16'h7060);
    ref_chk(2'b10);
    set_cnt(16'h0005);
    ref_chk(2'b01);
    set_cnt(16'h0010);
    ref_chk(2'b00);
    // external clear only on the channel that enables it
    wr(8'h18, 16'h50d0);
    ref_chk(2'b11);
    @(posedge ref_clk);
    trig.filtered_external_trigger <= 1'b1;
    ref_chk(2'b10);
    @(posedge ref_clk);
    trig.filtered_external_trigger <= 1'b0;
    ref_chk(2'b11);
    // preloaded compare waits for the software update
    set_cnt(16'h0000);
    wr(8'h18, 16'h0040);
    ref_chk(2'b10);
    wr(8'h18, 16'h0018);
    wr(8'h34, 16'h0030);
    set_cnt(16'h0030);
    ref_chk(2'b10);
    set_cnt(16'h0000);
    wr(8'h14, 16'h0001);
    #1 chk("counter_reinit", 16'h0001, {15'h0000, counter_reinit});
    set_cnt(16'h0030);
    ref_chk(2'b11);
    @(posedge ref_clk);
    protection_level <= 2'h3;
    wr(8'h18, 16'h00c4);
    rd_chk("locked_mode", 8'h18, 16'h009c);
    @(posedge ref_clk);
    protection_level <= 2'h0;
    // capture source per select code, both channels disabled
    trig.timer_input_one <= 1'b1;
    trig.internal_trigger_source <= 1'b1;
    for (int s = 1; s < 4; s++)
    begin
      wr(8'h18, {6'h00, 2'(s), 6'h00, 2'(s)});
      repeat (2) @(posedge ref_clk);
      #1 chk("capture_input", {14'h0000, s != 1, s != 2}, {14'h0000, capture_input});
    end
    // both inputs, levels held high, both capture sources high
    rd_chk("status_input", 8'h40, 16'h003c);
    @(posedge ref_clk);
    channel_enable <= 2'b01;
    wr(8'h18, 16'h0000);
    rd_chk("select_lock", 8'h18, 16'h0003);
    @(posedge ref_clk);
    channel_enable <= 2'b00;
    // move the counter off the ch1 compare so only the trigger can set it
    set_cnt(16'h0000);
    wr(8'h18, 16'h4044);
    wr(8'h18, 16'h4014);
    ref_chk(2'b00);
    @(posedge ref_clk);
    trig.trigger_event <= 1'b1;
    @(posedge ref_clk);
    trig.trigger_event <= 1'b0;
    ref_chk(2'b01);
    print_verdict();
  end
endmodule : tccm_channel_ctrl_test
